// [src/port4_cs_pkg.sv]
// package: register map, field layout, resets and modes of the chip-select port
package port4_cs_pkg;

    // =========================================
    // register offsets (avalon byte addresses = index * 4)
    localparam int unsigned IDX_SELECT_CTRL_A = 'hC2;
    localparam int unsigned IDX_SELECT_CTRL_B = 'hC3;
    localparam int unsigned IDX_PORT_DATA     = 'hD8;
    localparam int unsigned IDX_EXPANSION     = 'hAE;
    localparam int unsigned IDX_BASE_FIRST    = 'hE0;
    localparam int unsigned ADDR_W            = 10;

    // =========================================
    // field layout of a select-control register, and the invert-bit position in the expansion register
    localparam int unsigned FUNC_HI_LSB = 6;
    localparam int unsigned CMP_HI_LSB  = 4;
    localparam int unsigned FUNC_LO_LSB = 2;
    localparam int unsigned CMP_LO_LSB  = 0;
    localparam int unsigned INV_LSB     = 4;

    // =========================================
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BASE_RESET = 8'h00;
    localparam logic [3:0] DATA_RESET = 4'hF;
    localparam logic [3:0] PIN_RESET  = 4'hF;

    // =========================================
    // pin roles and compare lengths
    typedef enum logic [1:0] {
        FN_GPIO,
        FN_RD,
        FN_WR,
        FN_RDWR
    } pin_function_t;

    typedef enum logic [1:0] {
        CMP_16,
        CMP_15,
        CMP_14,
        CMP_8
    } mask_len_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
    } xdata_access_t;

endpackage

// [src/port4_chip_select_decoder.sv]
// four-pin port: gpio or address-decoded chip-select strobes, avalon-mm registers
// =========================================
// Functional notes
// - pin 3 function code: 00 gpio, 01 read, 10 write, 11 read/write strobe.
// - pin 3 compare length: 00 all, 01 A15-A1, 10 A15-A2, 11 A15-A8.
// - strobe window uses that pin's own base and compare length.
// - second control bits 3:2 are pin 2 function, same encoding.
// - second control bits 1:0 are pin 2 compare length, same encoding.
// - first control bits 7:6 are pin 1 function.
// - first control bits 5:4 are pin 1 compare length.
// - first control bits 3:2 are pin 0 function.
// - first control bits 1:0 are pin 0 compare length.
// - data bits 3:0 drive gpio pins only; bits 7:4 reserved.
// - strobes active low; per-pin invert bit makes them active high.
// - base 1234H, two bits masked: writes 1234H-1237H assert strobe.
// - read strobe follows core read one clock later during a matching access.
// - write strobe follows core write; read/write follows either.
// - each pin has high and low base registers forming 16 bits.
// - reset clears control and base registers; pins come up high.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module port4_chip_select_decoder
    import port4_cs_pkg::*;
#(
    parameter int unsigned PIN_COUNT = 4
) (
    // clock, reset, enable
    input  wire logic                          sys_clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          clk_en_in,
    // avalon-mm slave
    input  wire logic [port4_cs_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [31:0]                   avs_writedata_in,
    input  wire logic [3:0]                    avs_byteenable_in,
    output logic      [31:0]                   avs_readdata_out,
    output logic                               avs_waitrequest_out,
    // core external data access
    input  wire port4_cs_pkg::xdata_access_t   xdata_in,
    // port pins
    input  wire logic [3:0]                    pin_in,
    output logic      [3:0]                    pin_out,
    output logic      [3:0]                    pin_oe_out
);
    import port4_cs_pkg::*;

    // =========================================
    // elaboration check
    // field layout is fixed at four pins, so no other count can be served
    if (PIN_COUNT != 4) begin : g_pin_count_bad
        $error("port4_chip_select_decoder serves exactly four pins");
    end

    // =========================================
    // decode helpers
    function automatic logic [15:0] cmp_mask(input logic [1:0] len);
        case (mask_len_t'(len))
            CMP_16:  cmp_mask = 16'hFFFF;
            CMP_15:  cmp_mask = 16'hFFFE;
            CMP_14:  cmp_mask = 16'hFFFC;
            CMP_8:   cmp_mask = 16'hFF00;
            default: cmp_mask = 16'hFFFF;
        endcase
    endfunction

    function automatic logic strobe_hit(input logic [1:0] fn, input logic rd, input logic wr);
        case (pin_function_t'(fn))
            FN_RD:   strobe_hit = rd;
            FN_WR:   strobe_hit = wr;
            FN_RDWR: strobe_hit = rd | wr;
            default: strobe_hit = 1'b0;
        endcase
    endfunction

    function automatic logic window_match(input logic [15:0] addr, input logic [15:0] base, input logic [1:0] len);
        window_match = ((addr ^ base) & cmp_mask(len)) == 16'h0000;
    endfunction

    // gpio follows its data bit; a strobe idles inactive at the programmed polarity
    function automatic logic pin_level(input logic gpio, input logic data_bit, input logic hit, input logic inv);
        if (gpio) begin
            pin_level = data_bit;
        end else begin
            pin_level = hit ^ ~inv;
        end
    endfunction

    // =========================================
    // registers
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [3:0] data_q;
    logic [7:0] expansion_q;
    logic [7:0] base_q [0:7];
    logic       wait_q;
    logic [31:0] rdata_q;
    logic [3:0] pin_q;
    logic [3:0] oe_q;

    // =========================================
    // bus decode
    wire logic [7:0] reg_idx    = avs_address_in[ADDR_W-1:2];
    wire logic       word_ok    = avs_address_in[1:0] == 2'b00;
    wire logic       acc_done   = (avs_read_in | avs_write_in) & ~wait_q;
    // a write lands only at the edge where waitrequest is already low
    wire logic       wr_fire    = avs_write_in & ~wait_q & avs_byteenable_in[0] & word_ok;
    wire logic       sel_a      = reg_idx == IDX_SELECT_CTRL_A[7:0];
    wire logic       sel_b      = reg_idx == IDX_SELECT_CTRL_B[7:0];
    wire logic       sel_data   = reg_idx == IDX_PORT_DATA[7:0];
    wire logic       sel_exp    = reg_idx == IDX_EXPANSION[7:0];
    wire logic       sel_base   = reg_idx[7:3] == IDX_BASE_FIRST[7:3];
    wire logic [2:0] base_sel   = reg_idx[2:0];
    wire logic [7:0] wbyte      = avs_writedata_in[7:0];
    wire logic       req_any    = avs_read_in | avs_write_in;

    // write strobes per register
    wire logic       we_a       = wr_fire & sel_a;
    wire logic       we_b       = wr_fire & sel_b;
    wire logic       we_data    = wr_fire & sel_data;
    wire logic       we_exp     = wr_fire & sel_exp;
    wire logic       we_base    = wr_fire & sel_base;

    // base read-back order: pin0 high, pin0 low, pin1 high, ...
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (!word_ok) begin
            rd_byte = 8'h00;
        end else if (sel_a) begin
            rd_byte = ctrl_a_q;
        end else if (sel_b) begin
            rd_byte = ctrl_b_q;
        end else if (sel_data) begin
            rd_byte = {4'h0, pin_in};
        end else if (sel_exp) begin
            rd_byte = expansion_q;
        end else if (sel_base) begin
            rd_byte = base_q[base_sel];
        end
    end

    // =========================================
    // per-pin field extraction
    wire logic [1:0] fn_f  [0:3];
    wire logic [1:0] len_f [0:3];
    assign fn_f[0]  = ctrl_a_q[FUNC_LO_LSB +: 2];
    assign len_f[0] = ctrl_a_q[CMP_LO_LSB +: 2];
    assign fn_f[1]  = ctrl_a_q[FUNC_HI_LSB +: 2];
    assign len_f[1] = ctrl_a_q[CMP_HI_LSB +: 2];
    assign fn_f[2]  = ctrl_b_q[FUNC_LO_LSB +: 2];
    assign len_f[2] = ctrl_b_q[CMP_LO_LSB +: 2];
    assign fn_f[3]  = ctrl_b_q[FUNC_HI_LSB +: 2];
    assign len_f[3] = ctrl_b_q[CMP_HI_LSB +: 2];

    // =========================================
    // strobe generation
    // registered, so strobes lag the core access by one clock; the core must hold
    // its external access for at least one clock for a strobe to show
    wire logic [15:0] base_w  [0:3];
    wire logic        match_w [0:3];
    wire logic        hit_w   [0:3];
    wire logic        gpio_w  [0:3];
    wire logic        inv_w   [0:3];
    wire logic [3:0]  pin_d;
    wire logic [3:0]  oe_d;

    assign base_w[0] = {base_q[0], base_q[1]};
    assign base_w[1] = {base_q[2], base_q[3]};
    assign base_w[2] = {base_q[4], base_q[5]};
    assign base_w[3] = {base_q[6], base_q[7]};

    assign match_w[0] = window_match(xdata_in.addr, base_w[0], len_f[0]);
    assign match_w[1] = window_match(xdata_in.addr, base_w[1], len_f[1]);
    assign match_w[2] = window_match(xdata_in.addr, base_w[2], len_f[2]);
    assign match_w[3] = window_match(xdata_in.addr, base_w[3], len_f[3]);

    assign hit_w[0] = match_w[0] & strobe_hit(fn_f[0], xdata_in.rd, xdata_in.wr);
    assign hit_w[1] = match_w[1] & strobe_hit(fn_f[1], xdata_in.rd, xdata_in.wr);
    assign hit_w[2] = match_w[2] & strobe_hit(fn_f[2], xdata_in.rd, xdata_in.wr);
    assign hit_w[3] = match_w[3] & strobe_hit(fn_f[3], xdata_in.rd, xdata_in.wr);

    assign gpio_w[0] = pin_function_t'(fn_f[0]) == FN_GPIO;
    assign gpio_w[1] = pin_function_t'(fn_f[1]) == FN_GPIO;
    assign gpio_w[2] = pin_function_t'(fn_f[2]) == FN_GPIO;
    assign gpio_w[3] = pin_function_t'(fn_f[3]) == FN_GPIO;

    assign inv_w[0] = expansion_q[INV_LSB];
    assign inv_w[1] = expansion_q[INV_LSB + 1];
    assign inv_w[2] = expansion_q[INV_LSB + 2];
    assign inv_w[3] = expansion_q[INV_LSB + 3];

    // pin levels; strobe pins never see the data latch
    assign pin_d[0] = pin_level(gpio_w[0], data_q[0], hit_w[0], inv_w[0]);
    assign pin_d[1] = pin_level(gpio_w[1], data_q[1], hit_w[1], inv_w[1]);
    assign pin_d[2] = pin_level(gpio_w[2], data_q[2], hit_w[2], inv_w[2]);
    assign pin_d[3] = pin_level(gpio_w[3], data_q[3], hit_w[3], inv_w[3]);

    // gpio only pulls low and lets the pull-up give a high; strobes always drive
    assign oe_d[0] = gpio_w[0] ? ~data_q[0] : 1'b1;
    assign oe_d[1] = gpio_w[1] ? ~data_q[1] : 1'b1;
    assign oe_d[2] = gpio_w[2] ? ~data_q[2] : 1'b1;
    assign oe_d[3] = gpio_w[3] ? ~data_q[3] : 1'b1;

    // =========================================
    // bus answer: one wait state, then waitrequest low for exactly one clock
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en_in) begin
            wait_q  <= ~req_any | acc_done;
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // =========================================
    // select controls
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_a_q <= CTRL_RESET;
            ctrl_b_q <= CTRL_RESET;
        end else if (clk_en_in) begin
            if (we_a) begin
                ctrl_a_q <= wbyte;
            end
            if (we_b) begin
                ctrl_b_q <= wbyte;
            end
        end
    end

    // =========================================
    // strobe polarity control
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            expansion_q <= CTRL_RESET;
        end else if (clk_en_in) begin
            if (we_exp) begin
                expansion_q <= wbyte;
            end
        end
    end

    // =========================================
    // data latch
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_q <= DATA_RESET;
        end else if (clk_en_in) begin
            // latch always written; strobe pins ignore it
            if (we_data) begin
                data_q <= wbyte[3:0];
            end
        end
    end

    // =========================================
    // base address bytes
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 8; i++) begin
                base_q[i] <= BASE_RESET;
            end
        end else if (clk_en_in) begin
            if (we_base) begin
                base_q[base_sel] <= wbyte;
            end
        end
    end

    // =========================================
    // pin levels: outputs straight from flip-flops, no decode glitches on the strobes
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_q <= PIN_RESET;
        end else if (clk_en_in) begin
            pin_q <= pin_d;
        end
    end

    // =========================================
    // pin enables
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_q <= 4'h0;
        end else if (clk_en_in) begin
            oe_q <= oe_d;
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign pin_out             = pin_q;
    assign pin_oe_out          = oe_q;

endmodule

`default_nettype wire

// [test/port4_cs_assertions.sv]
// checker: bus handshake and pin timing of the chip-select port
`timescale 1ns/1ps
`default_nettype none
module port4_cs_assertions
    import port4_cs_pkg::*;
(
    // clock and reset
    input wire logic                         sys_clk_in,
    input wire logic                         sys_rst_in,
    input wire logic                         clk_en_in,
    // bus
    input wire logic                         avs_read_in,
    input wire logic                         avs_write_in,
    input wire logic [31:0]                  avs_readdata_out,
    input wire logic                         avs_waitrequest_out,
    // core access and pins
    input wire port4_cs_pkg::xdata_access_t  xdata_in,
    input wire logic [3:0]                   pin_out,
    input wire logic [3:0]                   pin_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // =========================================
    // helpers: pins may only move after an access change or a register write
    logic [17:0] xd_q;
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) xd_q <= '0;
        else if (clk_en_in) xd_q <= xdata_in;
    end
    wire cause = (xdata_in != xd_q) || (avs_write_in && !avs_waitrequest_out);
    sequence s_pending;
        (avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in;
    endsequence
    sequence s_taken;
        !avs_waitrequest_out;
    endsequence
    // =========================================
    property p_reset_pins;
        $fell(sys_rst_in) |-> pin_out == 4'hF && pin_oe_out == 4'h0;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not at reset level");
    property p_answer;
        s_pending |=> s_taken;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    property p_one_cycle;
        s_taken |=> avs_waitrequest_out;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("waitrequest low too long");
    property p_answer_cause;
        s_taken |-> $past(avs_read_in || avs_write_in);
    endproperty
    a_answer_cause: assert property (p_answer_cause) else $error("answer without request");
    property p_idle;
        !(avs_read_in || avs_write_in) |=> avs_waitrequest_out;
    endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low while idle");
    property p_upper_zero;
        s_taken |-> avs_readdata_out[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved read bits set");
    property p_pin_cause;
        $changed(pin_out) |-> $past(cause) || $past(cause, 2);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin moved without cause");
    property p_oe_cause;
        $changed(pin_oe_out) |-> $past(cause) || $past(cause, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved without cause");
endmodule
bind port4_chip_select_decoder port4_cs_assertions chk_u (.sys_clk_in, .sys_rst_in, .clk_en_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .xdata_in, .pin_out, .pin_oe_out);
`default_nettype wire

// [test/peripheral_pins.sv]
// far-side model: pin wires with pull-ups seen by the selected chips
`timescale 1ns/1ps
`default_nettype none
module peripheral_pins (
    // from the port
    input  wire logic [3:0] drive_in,
    input  wire logic [3:0] enable_in,
    // resolved levels
    output logic      [3:0] level_out
);
    // released pins float high through the pull-up
    assign level_out = ~enable_in | drive_in;
endmodule
`default_nettype wire

// [test/port4_chip_select_decoder_bench.sv]
// bench: registers, strobe windows and gpio of the chip-select port
`timescale 1ns/1ps
`default_nettype none
module port4_chip_select_decoder_bench;
    import port4_cs_pkg::*;
    logic          clk = 0;
    logic          rst = 1;
    logic          rd = 0;
    logic          wr = 0;
    logic          en = 1;
    logic [3:0]    be = 4'hF;
    logic [1:0]    mis = 2'b00;
    logic          wq;
    logic [9:0]    adr = '0;
    logic [31:0]   wd = '0;
    logic [31:0]   rdq;
    logic [3:0]    lvl;
    logic [3:0]    pout;
    logic [3:0]    poe;
    xdata_access_t xd = '0;
    int            fails = 0;
    int            cmp_count = 0;
    always #20 clk = ~clk;
    port4_chip_select_decoder dut_u (.sys_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdq), .avs_waitrequest_out(wq),
        .xdata_in(xd), .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe));
    peripheral_pins far_u (.drive_in(pout), .enable_in(poe), .level_out(lvl));
    // =========================================
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // hold the request until waitrequest is seen low, bounded
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        q = 8'h00;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= {idx, mis};
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 20);
        if (wq !== 1'b0) begin
            fails++;
            end_of_test();
        end else begin
            q = rdq[7:0];
            wr <= 0;
            rd <= 0;
        end
    endtask
    task automatic acc(input logic [15:0] a, input logic r, input logic [3:0] act, input logic [3:0] idle);
        @(posedge clk);
        xd <= '{addr: a, rd: r, wr: !r};
        @(posedge clk);
        @(negedge clk);
        chk("pins in access", {4'h0, act}, {4'h0, pout});
        @(posedge clk);
        xd <= '0;
        @(posedge clk);
        @(negedge clk);
        chk("pins idle", {4'h0, idle}, {4'h0, pout});
    endtask
    // =========================================
    task automatic t_reset();
        logic [7:0] q;
        chk("pins", 8'h0F, {4'h0, pout});
        chk("enables", 8'h00, {4'h0, poe});
        bus(0, 8'hC2, 0, q); chk("ctrl a", 8'h00, q);
        bus(0, 8'hC3, 0, q); chk("ctrl b", 8'h00, q);
        bus(0, 8'hE0, 0, q); chk("base", 8'h00, q);
        bus(0, 8'h10, 0, q); chk("unmapped", 8'h00, q);
        $display("reset test done");
    endtask
    task automatic t_write_window();
        logic [7:0] q;
        bus(1, 8'hE0, 8'h12, q);
        bus(1, 8'hE1, 8'h34, q);
        bus(1, 8'hC2, 8'h0A, q);
        bus(1, 8'hAE, 8'h10, q);
        bus(0, 8'hC2, 0, q); chk("ctrl a", 8'h0A, q);
        for (int a = 16'h1234; a <= 16'h1237; a++) acc(16'(a), 0, 4'hF, 4'hE);
        acc(16'h1238, 0, 4'hE, 4'hE);
        acc(16'h1234, 1, 4'hE, 4'hE);
        $display("write window test done");
    endtask
    task automatic t_read_window();
        logic [7:0] q;
        bus(1, 8'hE6, 8'h40, q);
        bus(1, 8'hE7, 8'h00, q);
        bus(1, 8'hC3, 8'h70, q);
        acc(16'h40FF, 1, 4'h6, 4'hE);
        acc(16'h40FF, 0, 4'hE, 4'hE);
        acc(16'h41FF, 1, 4'hE, 4'hE);
        bus(1, 8'hC3, 8'hF0, q);
        acc(16'h4000, 0, 4'h6, 4'hE);
        acc(16'h1234, 0, 4'hF, 4'hE);
        $display("read window test done");
    endtask
    task automatic t_gpio();
        logic [7:0] q;
        bus(1, 8'hD8, 8'h05, q);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("gpio pins", 8'h0C, {4'h0, pout});
        chk("gpio enables", 8'h0B, {4'h0, poe});
        bus(0, 8'hD8, 0, q); chk("pin levels", 8'h0C, {4'h0, q[3:0]});
        $display("gpio test done");
    endtask
    task automatic t_refuse();
        logic [7:0] q;
        be <= 4'h0;
        bus(1, 8'hC2, 8'hFF, q);
        be <= 4'hF;
        mis <= 2'b01;
        bus(1, 8'hC2, 8'hFF, q);
        bus(0, 8'hC2, 0, q); chk("misaligned read", 8'h00, q);
        mis <= 2'b00;
        bus(1, 8'h10, 8'hFF, q);
        bus(0, 8'h10, 0, q); chk("unmapped write", 8'h00, q);
        bus(0, 8'hC2, 0, q); chk("ctrl a kept", 8'h0A, q);
        @(posedge clk);
        en <= 1'b0;
        xd <= '{addr: 16'h4000, rd: 1'b1, wr: 1'b0};
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("frozen pins", 8'h0C, {4'h0, pout});
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("enabled pins", 8'h04, {4'h0, pout});
        @(posedge clk);
        xd <= '0;
        @(posedge clk);
        @(negedge clk);
        chk("released pins", 8'h0C, {4'h0, pout});
        $display("refusal test done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        t_reset();
        t_write_window();
        t_read_window();
        t_gpio();
        t_refuse();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
